// ---- dspx_dec_reg.sv ----
// Output register stage for the decoded instruction
`timescale 1ns/1ns
`default_nettype none

module dspx_dec_reg (
   // Clock and control
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   // Decode in and out
   input  wire dspx_pkg::dspx_dec_t d,
   output var  dspx_pkg::dspx_dec_t q
);

   dspx_pkg::dspx_dec_t q_d;

   always_comb
   begin
      q_d = q;
      if (ce)
      begin
         q_d = d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         q <= '0;
      end
      else
      begin
         q <= q_d;
      end
   end

endmodule : dspx_dec_reg

`default_nettype wire

// ---- dspx_decoder.sv ----
// DSP extension sub-class decoder: compare, abs, shift, load, dot
`timescale 1ns/1ns
`default_nettype none
`include "dspx_map.svh"

module dspx_decoder #(
   parameter logic RSVD_TRAP = 1'b1
) (
   // Clock and control
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                ce,
   // Instruction from fetch/issue
   input  wire logic                instr_valid,
   input  wire logic [31:0]         instr,
   input  wire logic                dsp_present,
   // Registered decode result
   output var  dspx_pkg::dspx_dec_t dec_q,
   // Same-cycle decode result
   output var  dspx_pkg::dspx_dec_t dec_now
);

   logic [5:0] major;
   logic [5:0] func;
   logic [4:0] sel;
   logic       in_group;

   assign major    = instr[`DSPX_MAJOR_HI:`DSPX_MAJOR_LO];
   assign func     = instr[`DSPX_FUNC_HI:`DSPX_FUNC_LO];
   assign sel      = instr[`DSPX_SEL_HI:`DSPX_SEL_LO];
   assign in_group = instr_valid && (major == `DSPX_GROUP_OPCODE);

   // Pure combinational decode, no state
   always_comb
   begin
      dspx_pkg::dspx_op_t op;
      dspx_pkg::dspx_cls_t cls;
      op  = dspx_pkg::OP_NONE;
      cls = dspx_pkg::CLS_NONE;
      dec_now = '0;
      dec_now.subop_selector      = sel;
      dec_now.first_source_field  = instr[`DSPX_SRC1_HI:`DSPX_SRC1_LO];
      dec_now.second_source_field = instr[`DSPX_SRC2_HI:`DSPX_SRC2_LO];
      dec_now.dest_field          = instr[`DSPX_DST_HI:`DSPX_DST_LO];
      dec_now.shift_amount_field  = instr[`DSPX_SRC1_HI:`DSPX_SRC1_LO];
      dec_now.imm10               = instr[`DSPX_IMM_HI:`DSPX_IMM_LO];
      dec_now.accumulator_select  = instr[`DSPX_ACC_HI:`DSPX_ACC_LO];

      if (in_group)
      begin
         // Row is sel[4:3], column sel[2:0]; one flat case covers both
         unique case (func)
            `DSPX_FUNC_CMP:
            begin
               cls = dspx_pkg::CLS_CMP;
               unique case (sel)
                  5'h00: op = dspx_pkg::OP_BYTE_CMP_EQ;
                  5'h01: op = dspx_pkg::OP_BYTE_CMP_LT;
                  5'h02: op = dspx_pkg::OP_BYTE_CMP_LE;
                  5'h03: op = dspx_pkg::OP_BYTE_PICK;
                  5'h04: op = dspx_pkg::OP_BYTE_CMP_EQ_TO_REG;
                  5'h05: op = dspx_pkg::OP_BYTE_CMP_LT_TO_REG;
                  5'h06: op = dspx_pkg::OP_BYTE_CMP_LE_TO_REG;
                  5'h08: op = dspx_pkg::OP_HALF_CMP_EQ;
                  5'h09: op = dspx_pkg::OP_HALF_CMP_LT;
                  5'h0a: op = dspx_pkg::OP_HALF_CMP_LE;
                  5'h0b: op = dspx_pkg::OP_HALF_PICK;
                  5'h0c: op = dspx_pkg::OP_FRAC_HALF_TO_BYTE_PACK;
                  5'h0d: op = dspx_pkg::OP_INT_HALF_TO_BYTE_PACK;
                  5'h0e: op = dspx_pkg::OP_HALF_PACK_RIGHT_LEFT;
                  5'h0f: op = dspx_pkg::OP_SAT_UNSIGNED_BYTE_PACK;
                  5'h14: op = dspx_pkg::OP_FRAC_WORD_TO_HALF_PACK;
                  5'h15: op = dspx_pkg::OP_FRAC_WORD_TO_HALF_PACK_RND;
                  5'h18: op = dspx_pkg::OP_BYTE_CMP_EQ_DUAL;
                  5'h1a: op = dspx_pkg::OP_BYTE_CMP_LE_DUAL;
                  5'h1e: op = dspx_pkg::OP_SRA_WORD_TO_HALF_PACK;
                  5'h1f: op = dspx_pkg::OP_SRA_WORD_TO_HALF_PACK_RND;
                  default: op = dspx_pkg::OP_NONE;
               endcase
            end
            `DSPX_FUNC_ABS:
            begin
               cls = dspx_pkg::CLS_ABS;
               unique case (sel)
                  5'h01: op = dspx_pkg::OP_BYTE_SAT_ABS;
                  5'h02: op = dspx_pkg::OP_BYTE_IMM_REPLICATE;
                  5'h03: op = dspx_pkg::OP_BYTE_REG_REPLICATE;
                  5'h04: op = dspx_pkg::OP_FRAC_BYTE_EXPAND_LEFT;
                  5'h05: op = dspx_pkg::OP_FRAC_BYTE_EXPAND_RIGHT;
                  5'h06: op = dspx_pkg::OP_FRAC_BYTE_EXPAND_LEFT_ALT;
                  5'h07: op = dspx_pkg::OP_FRAC_BYTE_EXPAND_RIGHT_ALT;
                  5'h09: op = dspx_pkg::OP_HALF_SAT_ABS;
                  5'h0a: op = dspx_pkg::OP_HALF_IMM_REPLICATE;
                  5'h0b: op = dspx_pkg::OP_HALF_REG_REPLICATE;
                  5'h0c: op = dspx_pkg::OP_FRAC_HALF_EXPAND_LEFT;
                  5'h0d: op = dspx_pkg::OP_FRAC_HALF_EXPAND_RIGHT;
                  5'h11: op = dspx_pkg::OP_WORD_SAT_ABS;
                  5'h1b: op = dspx_pkg::OP_BIT_REVERSE;
                  5'h1c: op = dspx_pkg::OP_UNSIGNED_BYTE_EXPAND_LEFT;
                  5'h1d: op = dspx_pkg::OP_UNSIGNED_BYTE_EXPAND_RIGHT;
                  5'h1e: op = dspx_pkg::OP_UNSIGNED_BYTE_EXPAND_LEFT_ALT;
                  5'h1f: op = dspx_pkg::OP_UNSIGNED_BYTE_EXPAND_RIGHT_ALT;
                  default: op = dspx_pkg::OP_NONE;
               endcase
               // Immediate forms spend bits 25..21 on the immediate
               if ((sel != `DSPX_SEL_BYTE_IMM_REPL)
                   && (sel != `DSPX_SEL_HALF_IMM_REPL)
                   && (instr[`DSPX_SRC1_HI:`DSPX_SRC1_LO] != 5'h00))
               begin
                  dec_now.field_err = 1'b1;
               end
            end
            `DSPX_FUNC_SHIFT:
            begin
               cls = dspx_pkg::CLS_SHIFT;
               unique case (sel)
                  5'h00: op = dspx_pkg::OP_BYTE_SHIFT_LEFT;
                  5'h01: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_LOGICAL;
                  5'h02: op = dspx_pkg::OP_BYTE_SHIFT_LEFT_REG;
                  5'h03: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_LOGICAL_REG;
                  5'h04: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_ARITH;
                  5'h05: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_ARITH_RND;
                  5'h06: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_ARITH_REG;
                  5'h07: op = dspx_pkg::OP_BYTE_SHIFT_RIGHT_ARITH_REG_RND;
                  5'h08: op = dspx_pkg::OP_HALF_SHIFT_LEFT;
                  5'h09: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_ARITH;
                  5'h0a: op = dspx_pkg::OP_HALF_SHIFT_LEFT_REG;
                  5'h0b: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_ARITH_REG;
                  5'h0c: op = dspx_pkg::OP_HALF_SAT_SHIFT_LEFT;
                  5'h0d: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_ARITH_RND;
                  5'h0e: op = dspx_pkg::OP_HALF_SAT_SHIFT_LEFT_REG;
                  5'h0f: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_ARITH_REG_RND;
                  5'h14: op = dspx_pkg::OP_WORD_SAT_SHIFT_LEFT;
                  5'h15: op = dspx_pkg::OP_WORD_SHIFT_RIGHT_ARITH_RND;
                  5'h16: op = dspx_pkg::OP_WORD_SAT_SHIFT_LEFT_REG;
                  5'h17: op = dspx_pkg::OP_WORD_SHIFT_RIGHT_ARITH_REG_RND;
                  5'h19: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_LOGICAL;
                  5'h1b: op = dspx_pkg::OP_HALF_SHIFT_RIGHT_LOGICAL_REG;
                  default: op = dspx_pkg::OP_NONE;
               endcase
            end
            `DSPX_FUNC_LOAD:
            begin
               // first source is base, second is index
               cls = dspx_pkg::CLS_LOAD;
               unique case (sel)
                  5'h00: op = dspx_pkg::OP_INDEXED_WORD_LOAD;
                  5'h04: op = dspx_pkg::OP_INDEXED_HALF_LOAD;
                  5'h06: op = dspx_pkg::OP_INDEXED_UBYTE_LOAD;
                  default: op = dspx_pkg::OP_NONE;
               endcase
            end
            `DSPX_FUNC_DOT:
            begin
               // Execute picks the variant from subop_selector
               cls = dspx_pkg::CLS_DOT;
               op  = dspx_pkg::OP_DOT_PRODUCT;
               if (instr[`DSPX_DST_TOP_HI:`DSPX_DST_TOP_LO] != 3'h0)
               begin
                  dec_now.field_err = 1'b1;
               end
            end
            default:
            begin
               cls = dspx_pkg::CLS_NONE;
               op  = dspx_pkg::OP_NONE;
            end
         endcase
      end

      dec_now.cls   = cls;
      dec_now.op    = op;
      dec_now.valid = (cls != dspx_pkg::CLS_NONE);
      dec_now.reserved = (cls != dspx_pkg::CLS_NONE)
                         && (op == dspx_pkg::OP_NONE);
      // Absent extension traps on the whole class, assigned or not
      dec_now.rsvd_exc = (cls != dspx_pkg::CLS_NONE)
                         && (!dsp_present
                             || (RSVD_TRAP && dec_now.reserved));
   end

   // Registered copy keeps dec_q flop-driven; dec_now stays combinational
   dspx_dec_reg u_dec_reg (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .d     (dec_now),
      .q     (dec_q)
   );

endmodule : dspx_decoder

`default_nettype wire

// ---- dspx_decoder_props.sv ----
// Port assertions for the DSP extension sub-class decoder
`timescale 1ns/1ns
`default_nettype none

module dspx_dec_props #(
   parameter logic RSVD_TRAP = 1'b1
) (
   // Clock and control
   input wire logic                clk,
   input wire logic                rst_b,
   input wire logic                ce,
   // Instruction
   input wire logic                instr_valid,
   input wire logic [31:0]         instr,
   input wire logic                dsp_present,
   // Decode results
   input wire dspx_pkg::dspx_dec_t dec_q,
   input wire dspx_pkg::dspx_dec_t dec_now
);
   logic [4:0] sel;
   logic [5:0] fn;
   logic       grp;
   assign sel = instr[10:6];
   assign fn  = instr[5:0];
   assign grp = instr_valid && instr[31:26] == 6'h1f;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_shift_class : assert property (
      grp && fn == 6'h13 |-> dec_now.valid && dec_now.cls == dspx_pkg::CLS_SHIFT)
      else $error("shift class missed");
   a_field_copy : assert property (
      instr_valid |-> {dec_now.first_source_field, dec_now.second_source_field,
                       dec_now.dest_field, dec_now.subop_selector} == instr[25:6])
      else $error("fields not copied");
   a_group_refuse : assert property (
      !grp |-> !dec_now.valid && !dec_now.rsvd_exc)
      else $error("foreign word accepted");
   a_absent_trap : assert property (
      grp && !dsp_present && dec_now.valid |-> dec_now.rsvd_exc)
      else $error("absent extension not trapped");
   a_rsvd_trap : assert property (
      dsp_present && dec_now.valid |->
         dec_now.rsvd_exc == (RSVD_TRAP && dec_now.reserved))
      else $error("reserved trap mismatch");
   a_dot_acc : assert property (
      grp && fn == 6'h30 |-> dec_now.accumulator_select == instr[12:11]
         && dec_now.field_err == (instr[15:13] != 3'h0))
      else $error("dot accumulator wrong");
   a_load_rsvd : assert property (
      grp && fn == 6'h0a |-> dec_now.reserved == !(sel inside {0, 4, 6}))
      else $error("load reserved wrong");
   a_abs_zero : assert property (
      grp && fn == 6'h12 && !(sel inside {5'h02, 5'h0a}) |->
         dec_now.field_err == (instr[25:21] != 5'h0))
      else $error("abs zero field check wrong");
   a_reg_copy : assert property (
      rst_b && ce |=> dec_q == $past(dec_now))
      else $error("registered copy wrong");
   a_ce_freeze : assert property (
      rst_b && !ce |=> $stable(dec_q))
      else $error("output moved without enable");
   // Own disable so the clearing edge itself is watched
   a_reset_clear : assert property (
      disable iff (1'b0) !rst_b |=> dec_q == '0)
      else $error("reset left decode");
endmodule : dspx_dec_props

bind dspx_decoder dspx_dec_props #(.RSVD_TRAP(RSVD_TRAP)) u_props (
   .clk(clk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid),
   .instr(instr), .dsp_present(dsp_present), .dec_q(dec_q),
   .dec_now(dec_now));

`default_nettype wire

// ---- dspx_fetch_model.sv ----
// Fetch/issue stage model feeding instruction words
`timescale 1ns/1ns
`default_nettype none

module dspx_fetch_model (
   // Clock
   input  wire logic        clk,
   // Instruction out
   output var  logic        instr_valid,
   output var  logic [31:0] instr
);
   logic [31:0] last_q;

   initial
   begin
      instr_valid = 1'b0;
      instr       = 32'h0;
      last_q      = 32'h0;
   end

   task automatic issue(input logic [31:0] w);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr       <= w;
      last_q      <= w;
   endtask : issue

   // Idle word is inverted so a stale word is never mistaken as held
   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      instr       <= ~last_q;
   endtask : idle
endmodule : dspx_fetch_model

`default_nettype wire

// ---- dspx_map.svh ----
// Encoding constants for the DSP extension sub-class decoder
`ifndef DSPX_MAP_SVH
`define DSPX_MAP_SVH

`define DSPX_MAJOR_HI       31
`define DSPX_MAJOR_LO       26
`define DSPX_SRC1_HI        25
`define DSPX_SRC1_LO        21
`define DSPX_SRC2_HI        20
`define DSPX_SRC2_LO        16
`define DSPX_DST_HI         15
`define DSPX_DST_LO         11
`define DSPX_DST_TOP_HI     15
`define DSPX_DST_TOP_LO     13
`define DSPX_ACC_HI         12
`define DSPX_ACC_LO         11
`define DSPX_IMM_HI         25
`define DSPX_IMM_LO         16
`define DSPX_SEL_HI         10
`define DSPX_SEL_LO         6
`define DSPX_FUNC_HI        5
`define DSPX_FUNC_LO        0

`define DSPX_GROUP_OPCODE   6'h1f
`define DSPX_FUNC_CMP       6'h11
`define DSPX_FUNC_ABS       6'h12
`define DSPX_FUNC_SHIFT     6'h13
`define DSPX_FUNC_LOAD      6'h0a
`define DSPX_FUNC_DOT       6'h30

`define DSPX_SEL_BYTE_IMM_REPL 5'h02
`define DSPX_SEL_HALF_IMM_REPL 5'h0a

`endif

// ---- dspx_pkg.sv ----
// Types shared by the DSP extension sub-class decoder
package dspx_pkg;

   typedef enum logic [2:0] {
      CLS_NONE,
      CLS_CMP,
      CLS_ABS,
      CLS_SHIFT,
      CLS_LOAD,
      CLS_DOT
   } dspx_cls_t;

   typedef enum logic [6:0] {
      OP_NONE,
      OP_BYTE_CMP_EQ,
      OP_BYTE_CMP_LT,
      OP_BYTE_CMP_LE,
      OP_BYTE_PICK,
      OP_BYTE_CMP_EQ_TO_REG,
      OP_BYTE_CMP_LT_TO_REG,
      OP_BYTE_CMP_LE_TO_REG,
      OP_HALF_CMP_EQ,
      OP_HALF_CMP_LT,
      OP_HALF_CMP_LE,
      OP_HALF_PICK,
      OP_FRAC_HALF_TO_BYTE_PACK,
      OP_INT_HALF_TO_BYTE_PACK,
      OP_HALF_PACK_RIGHT_LEFT,
      OP_SAT_UNSIGNED_BYTE_PACK,
      OP_FRAC_WORD_TO_HALF_PACK,
      OP_FRAC_WORD_TO_HALF_PACK_RND,
      OP_BYTE_CMP_EQ_DUAL,
      OP_BYTE_CMP_LE_DUAL,
      OP_SRA_WORD_TO_HALF_PACK,
      OP_SRA_WORD_TO_HALF_PACK_RND,
      OP_BYTE_SAT_ABS,
      OP_BYTE_IMM_REPLICATE,
      OP_BYTE_REG_REPLICATE,
      OP_FRAC_BYTE_EXPAND_LEFT,
      OP_FRAC_BYTE_EXPAND_RIGHT,
      OP_FRAC_BYTE_EXPAND_LEFT_ALT,
      OP_FRAC_BYTE_EXPAND_RIGHT_ALT,
      OP_HALF_SAT_ABS,
      OP_HALF_IMM_REPLICATE,
      OP_HALF_REG_REPLICATE,
      OP_FRAC_HALF_EXPAND_LEFT,
      OP_FRAC_HALF_EXPAND_RIGHT,
      OP_WORD_SAT_ABS,
      OP_BIT_REVERSE,
      OP_UNSIGNED_BYTE_EXPAND_LEFT,
      OP_UNSIGNED_BYTE_EXPAND_RIGHT,
      OP_UNSIGNED_BYTE_EXPAND_LEFT_ALT,
      OP_UNSIGNED_BYTE_EXPAND_RIGHT_ALT,
      OP_BYTE_SHIFT_LEFT,
      OP_BYTE_SHIFT_RIGHT_LOGICAL,
      OP_BYTE_SHIFT_LEFT_REG,
      OP_BYTE_SHIFT_RIGHT_LOGICAL_REG,
      OP_BYTE_SHIFT_RIGHT_ARITH,
      OP_BYTE_SHIFT_RIGHT_ARITH_RND,
      OP_BYTE_SHIFT_RIGHT_ARITH_REG,
      OP_BYTE_SHIFT_RIGHT_ARITH_REG_RND,
      OP_HALF_SHIFT_LEFT,
      OP_HALF_SHIFT_RIGHT_ARITH,
      OP_HALF_SHIFT_LEFT_REG,
      OP_HALF_SHIFT_RIGHT_ARITH_REG,
      OP_HALF_SAT_SHIFT_LEFT,
      OP_HALF_SHIFT_RIGHT_ARITH_RND,
      OP_HALF_SAT_SHIFT_LEFT_REG,
      OP_HALF_SHIFT_RIGHT_ARITH_REG_RND,
      OP_WORD_SAT_SHIFT_LEFT,
      OP_WORD_SHIFT_RIGHT_ARITH_RND,
      OP_WORD_SAT_SHIFT_LEFT_REG,
      OP_WORD_SHIFT_RIGHT_ARITH_REG_RND,
      OP_HALF_SHIFT_RIGHT_LOGICAL,
      OP_HALF_SHIFT_RIGHT_LOGICAL_REG,
      OP_INDEXED_WORD_LOAD,
      OP_INDEXED_HALF_LOAD,
      OP_INDEXED_UBYTE_LOAD,
      OP_DOT_PRODUCT
   } dspx_op_t;

   // Decoded instruction as handed to the execute stage
   typedef struct packed {
      logic       valid;
      dspx_cls_t  cls;
      dspx_op_t   op;
      logic [4:0] subop_selector;
      logic [4:0] first_source_field;
      logic [4:0] second_source_field;
      logic [4:0] dest_field;
      logic [4:0] shift_amount_field;
      logic [9:0] imm10;
      logic [1:0] accumulator_select;
      logic       reserved;
      logic       field_err;
      logic       rsvd_exc;
   } dspx_dec_t;

endpackage : dspx_pkg

// ---- tb_top.sv ----
// Self-checking bench for the DSP extension sub-class decoder
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("wrong value %s exp %0h got %0h", n, e, g); \
      end \
   end

module tb_top;
   logic                clk;
   logic                rst_b;
   logic                ce;
   logic                dsp_present;
   wire logic           instr_valid;
   wire logic [31:0]    instr;
   dspx_pkg::dspx_dec_t dec_q;
   dspx_pkg::dspx_dec_t dec_now;
   int                  fails;
   int                  total_checks;
   localparam logic [5:0] FN [5] = '{6'h11, 6'h12, 6'h13, 6'h0a, 6'h30};

   dspx_fetch_model u_fetch (.clk(clk), .instr_valid(instr_valid),
                             .instr(instr));
   dspx_decoder #(.RSVD_TRAP(1'b1)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
      .instr_valid(instr_valid), .instr(instr), .dsp_present(dsp_present),
      .dec_q(dec_q), .dec_now(dec_now));

   always #4 clk = ~clk;

   function automatic dspx_pkg::dspx_op_t exp_op(input logic [5:0] f,
                                                 input logic [4:0] s);
      int b;
      b = 0;
      case (f)
         6'h11:
            if (s < 5'h07) b = dspx_pkg::OP_BYTE_CMP_EQ + s;
            else if (s[4:3] == 2'h1) b = dspx_pkg::OP_HALF_CMP_EQ + s[2:0];
            else if (s[4:1] == 4'ha)
               b = dspx_pkg::OP_FRAC_WORD_TO_HALF_PACK + s[0];
            else if (s == 5'h18) b = dspx_pkg::OP_BYTE_CMP_EQ_DUAL;
            else if (s == 5'h1a) b = dspx_pkg::OP_BYTE_CMP_LE_DUAL;
            else if (s[4:1] == 4'hf)
               b = dspx_pkg::OP_SRA_WORD_TO_HALF_PACK + s[0];
         6'h12:
            if (s inside {[1:7]}) b = dspx_pkg::OP_BYTE_SAT_ABS + s - 1;
            else if (s inside {[9:13]}) b = dspx_pkg::OP_HALF_SAT_ABS + s - 9;
            else if (s == 5'h11) b = dspx_pkg::OP_WORD_SAT_ABS;
            else if (s == 5'h1b) b = dspx_pkg::OP_BIT_REVERSE;
            else if (s[4:2] == 3'h7)
               b = dspx_pkg::OP_UNSIGNED_BYTE_EXPAND_LEFT + s[1:0];
         6'h13:
            if (!s[4]) b = dspx_pkg::OP_BYTE_SHIFT_LEFT + s;
            else if (s[4:2] == 3'h5)
               b = dspx_pkg::OP_WORD_SAT_SHIFT_LEFT + s[1:0];
            else if (s == 5'h19) b = dspx_pkg::OP_HALF_SHIFT_RIGHT_LOGICAL;
            else if (s == 5'h1b) b = dspx_pkg::OP_HALF_SHIFT_RIGHT_LOGICAL_REG;
         6'h0a:
            if (s == 5'h00) b = dspx_pkg::OP_INDEXED_WORD_LOAD;
            else if (s == 5'h04) b = dspx_pkg::OP_INDEXED_HALF_LOAD;
            else if (s == 5'h06) b = dspx_pkg::OP_INDEXED_UBYTE_LOAD;
         default:
            b = dspx_pkg::OP_DOT_PRODUCT;
      endcase
      return dspx_pkg::dspx_op_t'(b);
   endfunction : exp_op

   // Every selector of every class, back to back with varied fields
   task automatic t_sweep();
      logic [31:0]        w;
      logic [19:0]        g;
      logic               fe;
      dspx_pkg::dspx_op_t op;
      dspx_pkg::dspx_op_t prev;
      prev = dspx_pkg::OP_NONE;
      for (int k = 0; k < 5; k++)
      begin
         for (int s = 0; s < 32; s++)
         begin
            w = {6'h1f, 5'(s ^ k), 5'(~s), 5'(s * 3), 5'(s), FN[k]};
            fe = (k == 1 && !(s inside {2, 10}) && w[25:21] != 5'h0) ||
                 (k == 4 && w[15:13] != 3'h0);
            op = exp_op(FN[k], 5'(s));
            u_fetch.issue(w);
            #1;
            g = {dec_now.first_source_field, dec_now.second_source_field,
                 dec_now.dest_field, dec_now.subop_selector};
            `CHK("cls", dspx_pkg::dspx_cls_t'(k + 1), dec_now.cls)
            `CHK("op", op, dec_now.op)
            `CHK("reserved", op == dspx_pkg::OP_NONE, dec_now.reserved)
            `CHK("rsvd_exc", op == dspx_pkg::OP_NONE, dec_now.rsvd_exc)
            `CHK("fields", w[25:6], g)
            `CHK("imm10", w[25:16], dec_now.imm10)
            `CHK("shamt", w[25:21], dec_now.shift_amount_field)
            `CHK("acc", w[12:11], dec_now.accumulator_select)
            `CHK("field_err", fe, dec_now.field_err)
            `CHK("dec_q op", prev, dec_q.op)
            prev = op;
         end
      end
      $display("sweep done");
   endtask : t_sweep

   // Foreign function, foreign major group, then a group word not valid
   task automatic t_refuse();
      for (int i = 0; i < 3; i++)
      begin
         if (i < 2) u_fetch.issue(i ? 32'h83ffffec : 32'h7c0000d0);
         else u_fetch.idle();
         #1;
         `CHK("valid", 1'b0, dec_now.valid)
         `CHK("op", dspx_pkg::OP_NONE, dec_now.op)
         `CHK("rsvd_exc", 1'b0, dec_now.rsvd_exc)
      end
      $display("refuse done");
   endtask : t_refuse

   task automatic t_absent();
      @(posedge clk);
      dsp_present <= 1'b0;
      for (int k = 0; k < 5; k++)
      begin
         u_fetch.issue({6'h1f, 5'h0, 5'h3, 5'h4, 5'h6, FN[k]});
         #1;
         `CHK("absent trap", 1'b1, dec_now.rsvd_exc)
      end
      @(posedge clk);
      dsp_present <= 1'b1;
      $display("absent done");
   endtask : t_absent

   // Enable low must freeze the copy; reset clears it regardless
   task automatic t_hold();
      u_fetch.issue(32'h7c000013);
      u_fetch.issue(32'h7c00000a);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("held op", dspx_pkg::OP_BYTE_SHIFT_LEFT, dec_q.op)
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("reset valid", 1'b0, dec_q.valid)
      `CHK("reset op", dspx_pkg::OP_NONE, dec_q.op)
      @(posedge clk);
      rst_b <= 1'b1;
      ce    <= 1'b1;
      u_fetch.idle();
      #1;
      `CHK("released op", dspx_pkg::OP_INDEXED_WORD_LOAD, dec_q.op)
      $display("hold done");
   endtask : t_hold

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   initial
   begin
      clk          = 1'b0;
      rst_b        = 1'b0;
      ce           = 1'b1;
      dsp_present  = 1'b1;
      fails        = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_sweep();
      t_refuse();
      t_absent();
      t_hold();
      summarize();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      fails++;
      $display("run limit reached");
      summarize();
   end
endmodule : tb_top

`default_nettype wire
